// >>> ccs_params.svh
// Constants for the CPU clock select and sleep timing block
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH
`define CCS_ADDR_CPU_CFG 9'h030
`define CCS_ADDR_IO_CFG 9'h032
`define CCS_ADDR_OSCILLATOR_CONTROL_0 9'h1e0
`define CCS_ADDR_MAIN_TRIM 9'h040
`define CCS_ADDR_SLOW_TRIM 9'h041
`define CCS_ADDR_SLOW_MODE 9'h042
`define CCS_ADDR_TIMER_SRC 9'h043
`define CCS_CPU_CFG_MASK 8'h01
`define CCS_IO_CFG_MASK 8'h1f
`define CCS_OSCILLATOR_CONTROL_0_MASK 8'h3f
`define CCS_SLOW_MODE_MASK 8'h01
`define CCS_TIMER_SRC_MASK 8'h0f
`define CCS_RST_BYTE 8'h00
`define CCS_TRIM_3V30_MAIN 8'h80
`define CCS_TRIM_3V30_SLOW 8'h80
`define CCS_BIT_CPU_SEL 0
`define CCS_BIT_NO_BUZZ 5
`define CCS_BIT_CRYSTAL_OSCILLATOR_SEL 4
`define CCS_BIT_CRYSTAL_OSCILLATOR_EN 3
`define CCS_BIT_FILT_DIS 2
`define CCS_SPEED_LSB 0
`define CCS_SLEEP_LSB 3
`define CCS_CLOCK_OUTPUT_PIN_LSB 0
`define CCS_FILT_LEN 3
`define CCS_DIV_W 8
`define CCS_SLEEP_CNT_W 6
`define CCS_DUTY_CNT_W 4
`define CCS_CLK_MAIN_HZ 40000000
`define CCS_DUTY_ON_CYC 4'h1
`define CCS_SLEEP_LIM_0 15'h003f
`define CCS_SLEEP_LIM_1 15'h01ff
`define CCS_SLEEP_LIM_2 15'h0fff
`define CCS_SLEEP_LIM_3 15'h7fff
`endif

// >>> ccs_pkg.sv
// Types for the CPU clock select and sleep timing block
package ccs_pkg;
  typedef logic [8:0] ccs_addr_t;
  typedef logic [7:0] ccs_byte_t;
  typedef enum logic [3:0] {
    CCS_SW_RUN = 4'b0001,
    CCS_SW_OFF = 4'b0010,
    CCS_SW_WAIT = 4'b0100,
    CCS_SW_ON = 4'b1000
  } ccs_sw_state_t;
endpackage

// >>> ccs_glitch_mux.sv
// Glitch-free two-input clock mux over sampled clock levels
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_glitch_mux
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Clock sources as levels
  input wire logic src0_i,
  input wire logic src1_i,
  input wire logic sel_i,
  // Selected clock
  output logic clk_o,
  output logic busy_o
);
  import ccs_pkg::*;
  ccs_sw_state_t state_q;
  logic sel_q;
  logic cur;
  logic nxt;

  assign cur = sel_q ? src1_i : src0_i;
  assign nxt = sel_i ? src1_i : src0_i;
  assign busy_o = (state_q != CCS_SW_RUN);

  // Switch only at low phases of both clocks
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= CCS_SW_RUN;
      sel_q <= 1'b0;
    end else begin
      case (state_q)
        CCS_SW_RUN: if (sel_i != sel_q) state_q <= CCS_SW_OFF;
        CCS_SW_OFF: if (!cur) state_q <= CCS_SW_WAIT;
        CCS_SW_WAIT: if (!nxt) begin
          sel_q <= sel_i;
          state_q <= CCS_SW_ON;
        end
        CCS_SW_ON: state_q <= CCS_SW_RUN;
        default: state_q <= CCS_SW_RUN;
      endcase
    end
  end

  // Old clock runs out its high phase, new one starts from low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      clk_o <= 1'b0;
    end else begin
      clk_o <= (state_q == CCS_SW_WAIT) ? 1'b0 : cur;
    end
  end
endmodule

// >>> ccs_divider.sv
// Programmable divide-by-2^k clock divider over a sampled clock level
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_divider
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Source level and divide exponent
  input wire logic src_i,
  input wire logic [2:0] exp_i,
  // Divided clock
  output logic clk_o
);
  import ccs_pkg::*;
  logic [`CCS_DIV_W-1:0] cnt_q;
  logic src_q;
  logic [2:0] exp_q;
  logic rise;

  assign rise = src_i & ~src_q;

  // Exponent is latched only at a full period boundary
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_q <= '0;
      src_q <= 1'b0;
      exp_q <= 3'h0;
      clk_o <= 1'b0;
    end else begin
      src_q <= src_i;
      if (rise) begin
        if (exp_q == 3'h0) begin
          clk_o <= 1'b1;
          exp_q <= exp_i;
        end else if (cnt_q == ((`CCS_DIV_W'(1) << (exp_q - 3'h1)) - 1'b1)) begin
          cnt_q <= '0;
          clk_o <= ~clk_o;
          if (clk_o) exp_q <= exp_i;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (!src_i && exp_q == 3'h0) begin
        clk_o <= 1'b0;
      end
    end
  end
endmodule

// >>> ccs_clock_ctrl.sv
// CPU clock select, speed divider, sleep timing and clock output control
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_ctrl
  import ccs_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Register port
  input wire ccs_pkg::ccs_addr_t addr_i,
  input wire ccs_pkg::ccs_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output ccs_pkg::ccs_byte_t rdata_o,
  // Oscillator levels, sampled
  input wire logic main_osc_i,
  input wire logic slow_osc_i,
  input wire logic crystal_osc_i,
  input wire logic clock_input_pin_i,
  // Sleep state
  input wire logic sleep_i,
  input wire logic sleep_duty_tick_i,
  // Oscillator controls
  output logic [7:0] main_osc_trim_o,
  output logic [7:0] slow_osc_trim_o,
  output logic slow_osc_accurate_o,
  output logic crystal_enable_o,
  output logic gpio_shared_oe_n_o,
  // Clocks out
  output logic cpu_clock_o,
  output logic cpu_switch_busy_o,
  output logic clock_output_pin_o,
  output logic ext_clock_o,
  output logic interval_timer_clock_o,
  output logic capture_timer_clock_o,
  output logic slow_seq_clock_o,
  // Sleep timing
  output logic sleep_tick_o,
  output logic [1:0] sleep_sel_o,
  output logic detector_enable_o
);
  import ccs_pkg::*;

  ccs_byte_t cpu_cfg_q;
  ccs_byte_t io_cfg_q;
  ccs_byte_t oscillator_control_0_q;
  ccs_byte_t main_trim_q;
  ccs_byte_t slow_trim_q;
  ccs_byte_t slow_mode_q;
  ccs_byte_t timer_src_q;
  ccs_byte_t rdata_d;

  // Write strobe aimed at one register
  function automatic logic wr_hit(input logic wr, input ccs_addr_t a,
                                  input ccs_addr_t reg_a);
    wr_hit = wr && (a == reg_a);
  endfunction

  // Register writes, reserved bits masked off
  always_ff @(posedge clk_i) begin
    if (srst_i) cpu_cfg_q <= `CCS_RST_BYTE;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_CPU_CFG))
      cpu_cfg_q <= wdata_i & `CCS_CPU_CFG_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) io_cfg_q <= `CCS_RST_BYTE;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_IO_CFG))
      io_cfg_q <= wdata_i & `CCS_IO_CFG_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) oscillator_control_0_q <= `CCS_RST_BYTE;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_OSCILLATOR_CONTROL_0))
      oscillator_control_0_q <= wdata_i & `CCS_OSCILLATOR_CONTROL_0_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) main_trim_q <= `CCS_TRIM_3V30_MAIN;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_MAIN_TRIM))
      main_trim_q <= wdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) slow_trim_q <= `CCS_TRIM_3V30_SLOW;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_SLOW_TRIM))
      slow_trim_q <= wdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) slow_mode_q <= `CCS_RST_BYTE;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_SLOW_MODE))
      slow_mode_q <= wdata_i & `CCS_SLOW_MODE_MASK;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) timer_src_q <= `CCS_RST_BYTE;
    else if (wr_hit(wr_i, addr_i, `CCS_ADDR_TIMER_SRC))
      timer_src_q <= wdata_i & `CCS_TIMER_SRC_MASK;
  end

  // Read mux, unmapped reads zero
  always_comb begin
    case (addr_i)
      `CCS_ADDR_CPU_CFG: rdata_d = cpu_cfg_q;
      `CCS_ADDR_IO_CFG: rdata_d = io_cfg_q;
      `CCS_ADDR_OSCILLATOR_CONTROL_0: rdata_d = oscillator_control_0_q;
      `CCS_ADDR_MAIN_TRIM: rdata_d = main_trim_q;
      `CCS_ADDR_SLOW_TRIM: rdata_d = slow_trim_q;
      `CCS_ADDR_SLOW_MODE: rdata_d = slow_mode_q;
      `CCS_ADDR_TIMER_SRC: rdata_d = timer_src_q;
      default: rdata_d = `CCS_RST_BYTE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) rdata_o <= `CCS_RST_BYTE;
    else if (rd_i) rdata_o <= rdata_d;
    else rdata_o <= `CCS_RST_BYTE;
  end

  // Field decode
  logic crystal_oscillator_en;
  logic crystal_oscillator_sel;
  logic filt_dis;
  logic [1:0] clock_output_pin_sel;
  logic [2:0] speed;
  logic [1:0] sleep_sel;
  logic no_buzz;
  assign crystal_oscillator_en = io_cfg_q[`CCS_BIT_CRYSTAL_OSCILLATOR_EN];
  assign crystal_oscillator_sel = io_cfg_q[`CCS_BIT_CRYSTAL_OSCILLATOR_SEL];
  assign filt_dis = io_cfg_q[`CCS_BIT_FILT_DIS];
  assign clock_output_pin_sel = io_cfg_q[`CCS_CLOCK_OUTPUT_PIN_LSB +: 2];
  assign speed = oscillator_control_0_q[`CCS_SPEED_LSB +: 3];
  assign sleep_sel = oscillator_control_0_q[`CCS_SLEEP_LSB +: 2];
  assign no_buzz = oscillator_control_0_q[`CCS_BIT_NO_BUZZ];

  assign main_osc_trim_o = main_trim_q;
  assign slow_osc_trim_o = slow_trim_q;
  assign slow_osc_accurate_o = slow_mode_q[0];
  assign crystal_enable_o = crystal_oscillator_en;
  assign gpio_shared_oe_n_o = crystal_oscillator_en;
  assign sleep_sel_o = sleep_sel;

  // Divide exponent per speed code; reserved codes hold prior value
  function automatic logic [2:0] speed_exp(input logic [2:0] code,
                                           input logic [2:0] prev);
    case (code)
      3'h0: speed_exp = 3'h3;
      3'h1: speed_exp = 3'h2;
      3'h2: speed_exp = 3'h1;
      3'h4: speed_exp = 3'h4;
      3'h5: speed_exp = 3'h5;
      3'h6: speed_exp = 3'h7;
      default: speed_exp = prev;
    endcase
  endfunction

  // Transient filter: level must hold for the filter length
  logic raw_ext;
  logic [`CCS_FILT_LEN-1:0] filt_sh_q;
  logic filt_q;
  logic ext_clk;
  assign raw_ext = (crystal_oscillator_en && crystal_oscillator_sel) ? crystal_osc_i
                                         : clock_input_pin_i;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      filt_sh_q <= '0;
      filt_q <= 1'b0;
    end else begin
      filt_sh_q <= {filt_sh_q[`CCS_FILT_LEN-2:0], raw_ext};
      if (&filt_sh_q) filt_q <= 1'b1;
      else if (~|filt_sh_q) filt_q <= 1'b0;
    end
  end
  assign ext_clk = filt_dis ? raw_ext : filt_q;
  assign ext_clock_o = ext_clk;

  // CPU source select then divider
  logic [2:0] exp_q;
  logic src_clk;
  logic div_clk;
  always_ff @(posedge clk_i) begin
    if (srst_i) exp_q <= 3'h3;
    else exp_q <= speed_exp(speed, exp_q);
  end

  ccs_glitch_mux u_mux (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .src0_i(main_osc_i),
    .src1_i(ext_clk),
    .sel_i(cpu_cfg_q[`CCS_BIT_CPU_SEL]),
    .clk_o(src_clk),
    .busy_o(cpu_switch_busy_o)
  );

  ccs_divider u_div (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .src_i(src_clk),
    .exp_i(exp_q),
    .clk_o(div_clk)
  );
  assign cpu_clock_o = div_clk;

  // Clock output pin source
  // Pad belongs to the crystal while it runs
  always_ff @(posedge clk_i) begin
    if (srst_i) clock_output_pin_o <= 1'b0;
    else if (crystal_oscillator_en) clock_output_pin_o <= 1'b0;
    else begin
      case (clock_output_pin_sel)
        2'h0: clock_output_pin_o <= main_osc_i;
        2'h1: clock_output_pin_o <= ext_clk;
        2'h2: clock_output_pin_o <= slow_osc_i;
        2'h3: clock_output_pin_o <= div_clk;
        default: clock_output_pin_o <= 1'b0;
      endcase
    end
  end

  // Timer clock sources, independent of CPU select
  function automatic logic timer_src(input logic [1:0] s, input logic m,
                                     input logic e, input logic l);
    case (s)
      2'h0: timer_src = m;
      2'h1: timer_src = e;
      2'h2: timer_src = l;
      default: timer_src = m;
    endcase
  endfunction
  assign interval_timer_clock_o =
    timer_src(timer_src_q[1:0], main_osc_i, ext_clk, slow_osc_i);
  assign capture_timer_clock_o =
    timer_src(timer_src_q[3:2], main_osc_i, ext_clk, slow_osc_i);
  assign slow_seq_clock_o = slow_osc_i;

  // Sleep tick from slow clock: 32768 / 2^(6 + 3k)
  logic slow_q;
  logic slow_rise;
  logic [14:0] sleep_cnt_q;
  logic [14:0] sleep_lim;
  always_comb begin
    case (sleep_sel)
      2'h0: sleep_lim = `CCS_SLEEP_LIM_0;
      2'h1: sleep_lim = `CCS_SLEEP_LIM_1;
      2'h2: sleep_lim = `CCS_SLEEP_LIM_2;
      default: sleep_lim = `CCS_SLEEP_LIM_3;
    endcase
  end
  assign slow_rise = slow_osc_i & ~slow_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      slow_q <= 1'b0;
      sleep_cnt_q <= '0;
      sleep_tick_o <= 1'b0;
    end else begin
      slow_q <= slow_osc_i;
      sleep_tick_o <= 1'b0;
      if (slow_rise) begin
        if (sleep_cnt_q >= sleep_lim) begin
          sleep_cnt_q <= '0;
          sleep_tick_o <= 1'b1;
        end else sleep_cnt_q <= sleep_cnt_q + 1'b1;
      end
    end
  end

  // Detector duty: own tick source, not the sleep interval
  logic [`CCS_DUTY_CNT_W-1:0] duty_q;
  always_ff @(posedge clk_i) begin
    if (srst_i) duty_q <= '0;
    else if (sleep_duty_tick_i) duty_q <= `CCS_DUTY_ON_CYC;
    else if (duty_q != '0) duty_q <= duty_q - 1'b1;
  end
  assign detector_enable_o = !sleep_i || no_buzz || (duty_q != '0);
endmodule

// >>> ccs_ext_model.sv
// Model of the external crystal and the clock input source
`timescale 1ns/1ps
module ccs_ext_model #(
  parameter int HALF = 4,
  parameter int START = 40
) (
  // Clock and crystal enable
  input wire logic clk_i,
  input wire logic xtal_en_i,
  // Source levels
  output logic crystal_o,
  output logic pin_o
);
  int cnt = 0;
  int age = 0;
  initial crystal_o = 1'b0;
  initial pin_o = 1'b0;
  always @(posedge clk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    age <= xtal_en_i ? age + 1 : 0;
    if (cnt == HALF - 1)
      pin_o <= ~pin_o;
    // Crystal stands still until start-up has passed
    if (xtal_en_i && age >= START && cnt == HALF - 1)
      crystal_o <= ~crystal_o;
  end
endmodule

// >>> ccs_clock_ctrl_properties.sv
// Checker for the CPU clock control block
`timescale 1ns/1ps
`include "ccs_params.svh"
module ccs_clock_ctrl_properties
  import ccs_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic srst_i,
  input wire ccs_pkg::ccs_addr_t addr_i,
  input wire ccs_pkg::ccs_byte_t wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire ccs_pkg::ccs_byte_t rdata_o,
  // Levels and sleep
  input wire logic slow_osc_i,
  input wire logic clock_input_pin_i,
  input wire logic sleep_i,
  // Outputs watched
  input wire logic [7:0] main_osc_trim_o,
  input wire logic [7:0] slow_osc_trim_o,
  input wire logic crystal_enable_o,
  input wire logic gpio_shared_oe_n_o,
  input wire logic clock_output_pin_o,
  input wire logic ext_clock_o,
  input wire logic sleep_tick_o,
  input wire logic [1:0] sleep_sel_o,
  input wire logic detector_enable_o
);
  logic [7:0] io_q;
  logic [7:0] osc_q;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);
  // Shadow copies of the written fields
  always_ff @(posedge clk_i) begin
    if (srst_i)
      io_q <= `CCS_RST_BYTE;
    else if (wr_i && addr_i == `CCS_ADDR_IO_CFG)
      io_q <= wdata_i & `CCS_IO_CFG_MASK;
  end
  always_ff @(posedge clk_i) begin
    if (srst_i)
      osc_q <= `CCS_RST_BYTE;
    else if (wr_i && addr_i == `CCS_ADDR_OSCILLATOR_CONTROL_0)
      osc_q <= wdata_i & `CCS_OSCILLATOR_CONTROL_0_MASK;
  end
  a_trim_at_reset: assert property (
    $past(srst_i) |-> main_osc_trim_o == `CCS_TRIM_3V30_MAIN &&
    slow_osc_trim_o == `CCS_TRIM_3V30_SLOW)
    else $error("trim not at default after reset");
  a_gpio_oe_follow: assert property (
    gpio_shared_oe_n_o == crystal_enable_o && crystal_enable_o == io_q[3])
    else $error("shared pad drivers not off with crystal");
  a_filter_bypass: assert property (
    io_q[2] && !io_q[3] && $rose(clock_input_pin_i) |-> ##[0:2] ext_clock_o)
    else $error("bypassed input not on external path");
  a_sleep_field: assert property (
    sleep_sel_o == osc_q[4:3])
    else $error("sleep select differs from written field");
  a_detector_on: assert property (
    !sleep_i || osc_q[5] |-> detector_enable_o)
    else $error("detector off while awake or overridden");
  a_io_readback: assert property (
    rd_i && addr_i == `CCS_ADDR_IO_CFG |=> rdata_o == $past(io_q))
    else $error("clock io readback wrong");
  a_tick_single: assert property (
    sleep_tick_o |=> !sleep_tick_o)
    else $error("sleep tick longer than one cycle");
  a_clock_output_pin_slow: assert property (
    io_q[1:0] == 2'b10 && !io_q[3] && $rose(slow_osc_i)
    |-> ##[0:4] clock_output_pin_o)
    else $error("clock output not following slow oscillator");
  c_tick: cover property (sleep_tick_o);
  c_duty: cover property (sleep_i && !osc_q[5] && detector_enable_o);
  c_xtal: cover property (crystal_enable_o && io_q[4]);
endmodule
bind ccs_clock_ctrl ccs_clock_ctrl_properties u_ccs_clock_ctrl_properties (.*);

// >>> tb.sv
// Self-checking bench for the CPU clock control block
`timescale 1ns/1ps
module tb;
  import ccs_pkg::*;
  localparam int LIMIT = 80000;
  logic clk_i, srst_i, wr_i, rd_i, main_osc_i, slow_osc_i;
  logic sleep_i, sleep_duty_tick_i, crystal_osc_i, clock_input_pin_i;
  ccs_addr_t addr_i;
  ccs_byte_t wdata_i, rdata_o;
  logic [7:0] main_osc_trim_o, slow_osc_trim_o;
  logic [1:0] sleep_sel_o;
  logic slow_osc_accurate_o, crystal_enable_o, gpio_shared_oe_n_o;
  logic cpu_clock_o, cpu_switch_busy_o, clock_output_pin_o, ext_clock_o;
  logic interval_timer_clock_o, capture_timer_clock_o, slow_seq_clock_o;
  logic sleep_tick_o, detector_enable_o;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int dv[8] = '{8, 4, 2, 0, 16, 32, 128, 0};
  // Rows: address, write value, read back, reset value
  ccs_addr_t ra[8] = '{9'h030, 9'h032, 9'h1e0, 9'h040, 9'h041, 9'h042,
    9'h043, 9'h031};
  ccs_byte_t rw[8] = '{8'hfe, 8'he7, 8'hff, 8'h5a, 8'hc3, 8'hff, 8'hff, 8'hff};
  ccs_byte_t rx[8] = '{8'h00, 8'h07, 8'h3f, 8'h5a, 8'hc3, 8'h01, 8'h0f, 8'h00};
  ccs_byte_t rr[8] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h00, 8'h00, 8'h00};
  wire logic [5:0] mon = {sleep_tick_o, ext_clock_o, capture_timer_clock_o,
    interval_timer_clock_o, clock_output_pin_o, cpu_clock_o};
  ccs_clock_ctrl u_ccs_clock_ctrl (.*);
  ccs_ext_model #(.HALF(4), .START(40)) u_ccs_ext_model (.clk_i(clk_i),
    .xtal_en_i(crystal_enable_o), .crystal_o(crystal_osc_i),
    .pin_o(clock_input_pin_i));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Oscillator levels and hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    main_osc_i <= cyc[1];
    slow_osc_i <= cyc[3];
    if (cyc == LIMIT) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic wr(input ccs_addr_t a, input ccs_byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input ccs_addr_t a, output ccs_byte_t d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rise(input int k);
    logic p;
    p = 1'b1;
    forever begin
      @(posedge clk_i);
      #1;
      if (mon[k] === 1'b1 && p === 1'b0)
        break;
      p = mon[k];
    end
  endtask
  task automatic per(input int k, input int e);
    int t0;
    rise(k);
    t0 = cyc;
    rise(k);
    chk($sformatf("period_%0d", k), cyc - t0, e);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    ccs_byte_t d, d2;
    logic s;
    {srst_i, wr_i, rd_i, sleep_i, sleep_duty_tick_i} = 5'b10000;
    {addr_i, wdata_i} = '0;
    repeat (12) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], d);
      chk("reset", d, rr[i]);
    end
    for (int i = 0; i < 8; i++) begin
      wr(ra[i], rw[i]);
      rd(ra[i], d);
      chk("readback", d, rx[i]);
    end
    chk("trim", main_osc_trim_o, 8'h5a);
    chk("slow_trim", slow_osc_trim_o, 8'hc3);
    chk("sleep_sel", sleep_sel_o, 2'h3);
    chk("slow_mode", slow_osc_accurate_o, 1'b1);
    // Speed codes on the internal source
    for (int c = 0; c < 7; c++) begin
      if (c != 3) begin
        wr(9'h1e0, 8'(c));
        repeat (1024) @(posedge clk_i);
        per(0, 4 * dv[c]);
        per(1, 4 * dv[c]);
      end
    end
    wr(9'h1e0, 8'h03);
    repeat (1024) @(posedge clk_i);
    per(0, 512);
    // External pin, filter bypassed then in use
    wr(9'h030, 8'h01);
    @(posedge clk_i);
    #1;
    chk("busy", cpu_switch_busy_o, 1'b1);
    wr(9'h1e0, 8'h02);
    repeat (1200) @(posedge clk_i);
    per(0, 16);
    chk("busy_done", cpu_switch_busy_o, 1'b0);
    per(4, 8);
    wr(9'h032, 8'h03);
    per(4, 8);
    // Crystal enabled, settled, selected, then released
    wr(9'h032, 8'h0b);
    chk("gpio_oe_n", gpio_shared_oe_n_o, 1'b1);
    repeat (100) @(posedge clk_i);
    wr(9'h032, 8'h1b);
    chk("clock_output_pin_xtal", clock_output_pin_o, 1'b0);
    repeat (200) @(posedge clk_i);
    per(0, 16);
    wr(9'h032, 8'h0b);
    wr(9'h032, 8'h03);
    chk("gpio_oe_n", gpio_shared_oe_n_o, 1'b0);
    wr(9'h030, 8'h00);
    wr(9'h043, 8'h02);
    per(2, 16);
    per(3, 4);
    wr(9'h043, 8'h08);
    per(2, 4);
    per(3, 16);
    wr(9'h032, 8'h00);
    per(1, 4);
    wr(9'h032, 8'h02);
    per(1, 16);
    // Sleep with one detector window
    wr(9'h1e0, 8'h00);
    sleep_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk("detector", detector_enable_o, 1'b0);
    chk("slow_seq", slow_seq_clock_o, slow_osc_i);
    @(posedge clk_i) sleep_duty_tick_i <= 1'b1;
    @(posedge clk_i) sleep_duty_tick_i <= 1'b0;
    s = 1'b0;
    repeat (3) begin
      #1 s = s | detector_enable_o;
      @(posedge clk_i);
    end
    chk("duty", s, 1'b1);
    per(5, 1024);
    wr(9'h1e0, 8'h20);
    chk("no_buzz", detector_enable_o, 1'b1);
    // Second reset in mid-run
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    #1;
    chk("trim_rst", main_osc_trim_o, 8'h80);
    rd(9'h1e0, d);
    chk("speed_rst", d, 8'h00);
    rd(9'h1e0, d2);
    chk("reread", d2, d);
    end_sim();
  end
endmodule
